// File: core/vic_control.sv
`timescale 1ns/1ps
`default_nettype none
// interrupt control: latches requests, arbitrates on phase-two ticks
module vic_control #(
    parameter int DEPTH = vic_pkg::STACK_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] dataAddr,
    input wire logic dataWrEn,
    input wire logic [7:0] dataWrData,
    output var logic [7:0] dataRdData,
    input wire logic extIrqPinN,
    input wire logic timerAOverflow,
    input wire logic timerBOverflow,
    input wire logic secondClockPhase,
    input wire logic callPush,
    input wire logic returnFromCall,
    input wire logic returnFromIrq,
    output var logic irqTake,
    output var logic [12:0] irqVector,
    output var logic wakeRequest,
    output var logic stackFull
);
    localparam int N = vic_pkg::NUM_SRC;
    localparam int FL = vic_pkg::FLAG_LSB;
    localparam int EL = vic_pkg::ENABLE_LSB;

    // refused at elaboration: the core's stack has a fixed depth
    if (DEPTH != vic_pkg::STACK_DEPTH) begin : g_bad_depth
        $error("vic_control: return stack depth is fixed at 16");
    end

    // lowest index wins: pin, then timer a, then timer b
    function automatic logic [2:0] vic_pick(input logic [2:0] req);
        vic_pick = req & ~(req - 3'h1);
    endfunction : vic_pick

    function automatic vic_pkg::vic_pc_t vic_vector(input logic [2:0] one);
        vic_vector = one[0] ? vic_pkg::VEC_PIN :
                     one[1] ? vic_pkg::VEC_TIMER_A :
                     vic_pkg::VEC_TIMER_B;
    endfunction : vic_vector

    vic_stack_if stk ();

    vic_stack_track #(.DEPTH(DEPTH)) u_track (
        .mclk(mclk),
        .rst(rst),
        .stk(stk)
    );

    logic [7:0] ctrlReg;
    logic pinPrev;
    logic [7:0] next_interrupt_control;
    logic [2:0] hwSet;
    logic [2:0] ready;
    logic [2:0] winner;
    logic [2:0] ackClr;
    logic wrHit;
    logic ackNow;
    logic masterOn;
    logic next_master;
    logic [2:0] flags;
    logic [2:0] enables;

    assign masterOn = ctrlReg[vic_pkg::MASTER_BIT];
    assign flags = ctrlReg[FL +: N];
    assign enables = ctrlReg[EL +: N];
    assign wrHit = dataWrEn && (dataAddr == vic_pkg::CTRL_ADDR);

    // request sources; the pin edge is taken from the previous sample
    assign hwSet[0] = pinPrev && !extIrqPinN;
    assign hwSet[1] = timerAOverflow;
    assign hwSet[2] = timerBOverflow;

    // arbitration only on a phase-two tick, so any request that arrived
    // since the previous tick is judged together with the others
    assign ready = flags & enables;
    assign winner = vic_pick(ready);
    assign ackNow = secondClockPhase && masterOn && (ready != 3'h0) &&
                    !stk.full;
    assign ackClr = ackNow ? winner : 3'h0;

    // master enable: acknowledge beats a return, a return beats a write
    assign next_master = ackNow ? 1'b0 :
                         returnFromIrq ? 1'b1 :
                         wrHit ? dataWrData[vic_pkg::MASTER_BIT] :
                         masterOn;

    // flags: a hardware set in the same cycle beats any clear, and a
    // cleared master enable never stops a flag from latching
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_src
            assign next_interrupt_control[FL + g] = hwSet[g] || (!ackClr[g] &&
                (wrHit ? dataWrData[FL + g] : flags[g]));
            assign next_interrupt_control[EL + g] = wrHit ? dataWrData[EL + g] :
                                       enables[g];
        end
    endgenerate
    assign next_interrupt_control[vic_pkg::MASTER_BIT] = next_master;
    assign next_interrupt_control[7] = 1'b0; // unused bit reads zero

    // only the program counter goes on the stack; the core saves the rest
    assign stk.push = callPush || ackNow;
    assign stk.pop = returnFromCall || returnFromIrq;

    // control register and pin edge history
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrlReg <= vic_pkg::CTRL_RESET;
            pinPrev <= 1'b1;
        end else begin
            ctrlReg <= next_interrupt_control & vic_pkg::MASK_REG;
            pinPrev <= extIrqPinN;
        end
    end

    // core-facing outputs, one cycle after the decision
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqTake <= 1'b0;
            irqVector <= 13'h000;
            wakeRequest <= 1'b0;
            dataRdData <= 8'h00;
        end else begin
            irqTake <= ackNow;
            irqVector <= ackNow ? vic_vector(winner) : irqVector;
            wakeRequest <= (next_interrupt_control[FL +: N] != 3'h0);
            dataRdData <= (dataAddr == vic_pkg::CTRL_ADDR) ? ctrlReg : 8'h00;
        end
    end

    assign stackFull = stk.full;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ack_clears_master_a: assert property (
        irqTake |-> !ctrlReg[vic_pkg::MASTER_BIT])
        else $error("master enable still set after acknowledge");
    masked_no_take_a: assert property (
        !masterOn |=> !irqTake)
        else $error("acknowledge while master enable clear");
    masked_flag_kept_a: assert property (
        !masterOn && timerAOverflow |=> flags[1])
        else $error("masked request lost its flag");
    nest_take_a: assert property (
        secondClockPhase && masterOn && (ready != 3'h0) && !stk.full
        |=> irqTake && !ctrlReg[vic_pkg::MASTER_BIT])
        else $error("enabled pending request not taken");
    full_withhold_a: assert property (
        stk.full && (flags != 3'h0) && !wrHit
        |=> !irqTake ##0 (flags != 3'h0))
        else $error("acknowledge while stack full");
    wake_on_flag_a: assert property (
        (flags != 3'h0) |-> wakeRequest)
        else $error("pending flag without wake request");
    push_on_take_a: assert property (
        ackNow && !stk.pop && !stk.full |=> stk.level == $past(stk.level)
        + 5'h01) else $error("acknowledge did not push");
    pin_edge_flag_a: assert property (
        $fell(extIrqPinN) && !$past(rst) |=> flags[0])
        else $error("pin falling edge missed");
    vector_pick_a: assert property (
        ackNow && ready[0] && !hwSet[0]
        |=> irqVector == vic_pkg::VEC_PIN && !flags[0] ##1
        1'b1) else $error("pin request lost arbitration");
    vector_timer_b_a: assert property (
        ackNow && ready == 3'h4 |=> irqVector == vic_pkg::VEC_TIMER_B)
        else $error("timer b vector wrong");
    return_from_irq_sets_master_a: assert property (
        returnFromIrq && !ackNow |=> masterOn)
        else $error("return from irq left master enable clear");
    tick_only_a: assert property (
        !secondClockPhase |=> !irqTake)
        else $error("acknowledge off a phase-two tick");

    take_pin_c: cover property (ackNow && winner == 3'h1);
    take_nested_c: cover property (irqTake ##[1:20] irqTake);
    held_by_full_c: cover property (stk.full && ready != 3'h0 ##1 stk.pop);
endmodule : vic_control
`default_nettype wire

// File: core/vic_pkg.sv
package vic_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h0b;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int MASTER_BIT = 0;
    localparam int ENABLE_LSB = 1;
    localparam int FLAG_LSB = 4;
    localparam int NUM_SRC = 3;
    localparam int PC_W = 13;
    localparam logic [12:0] VEC_PIN = 13'h004;
    localparam logic [12:0] VEC_TIMER_A = 13'h008;
    localparam logic [12:0] VEC_TIMER_B = 13'h00c;
    localparam int STACK_DEPTH = 16;
    localparam logic [7:0] MASK_REG = 8'h7f;
    typedef logic [12:0] vic_pc_t;
endpackage : vic_pkg

// File: core/vic_stack_if.sv
`timescale 1ns/1ps
`default_nettype none
// push and pop strobes towards the return stack tracker
interface vic_stack_if;
    logic push;
    logic pop;
    logic full;
    logic [4:0] level;
    modport tracker (input push, input pop, output full, output level);
    modport user (output push, output pop, input full, input level);
endinterface : vic_stack_if
`default_nettype wire

// File: core/vic_stack_track.sv
`timescale 1ns/1ps
`default_nettype none
// follows the return stack pointer; the stack itself lives in the core
module vic_stack_track #(
    parameter int DEPTH = vic_pkg::STACK_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    vic_stack_if.tracker stk
);
    localparam logic [4:0] TOP = 5'(DEPTH);

    // refused at elaboration: the level counter is five bits wide
    if (DEPTH < 1 || DEPTH > 31) begin : g_bad_depth
        $error("vic_stack_track: DEPTH must be 1..31");
    end

    logic [4:0] level;
    logic atTop;
    logic empty;
    logic [4:0] next_level;

    assign atTop = (level == TOP);
    assign empty = (level == 5'h00);
    // a push on a full stack overwrites the oldest entry, so depth saturates
    assign next_level = (stk.push && !stk.pop && !atTop) ? level + 5'h01 :
                        (stk.pop && !stk.push && !empty) ? level - 5'h01 :
                        level;

    // level and full are registered together so they never disagree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level <= 5'h00;
            stk.full <= 1'b0;
        end else begin
            level <= next_level;
            stk.full <= (next_level == TOP);
        end
    end

    assign stk.level = level;

    depth_bound_a: assert property (@(posedge mclk) disable iff (rst)
        level <= TOP) else $error("stack level above depth");
endmodule : vic_stack_track
`default_nettype wire

// File: testbench/vectored_interrupt_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_control_tb;
    logic mclk, rst, dataWrEn, tickEn, irqTake, wakeRequest, stackFull;
    wire logic extIrqPinN, timerAOverflow, timerBOverflow, secondClockPhase;
    wire logic callPush, returnFromCall, returnFromIrq;
    logic [5:0] evt;
    logic [7:0] dataAddr, dataWrData, dataRdData;
    logic [12:0] irqVector;
    logic [12:0] takeCount = 13'h0;
    int errCount, checkCount;
    // one-hot event strobes; pin idles high
    assign {returnFromIrq, returnFromCall, callPush} = evt[5:3];
    assign {timerBOverflow, timerAOverflow} = evt[2:1];
    assign extIrqPinN = ~evt[0];
    vic_control vic_control_i (.mclk, .rst, .dataAddr, .dataWrEn,
        .dataWrData, .dataRdData, .extIrqPinN, .timerAOverflow,
        .timerBOverflow, .secondClockPhase, .callPush, .returnFromCall,
        .returnFromIrq, .irqTake, .irqVector, .wakeRequest, .stackFull);
    vic_core_model vic_core_model_i (.mclk, .rst, .tickEn,
        .secondClockPhase);
    // count acknowledges so refusals can be shown
    always @(posedge mclk) if (irqTake === 1'b1) takeCount <= takeCount + 13'h1;
    task chk(input logic [12:0] got, input logic [12:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] v);
        @(posedge mclk);
        dataAddr <= 8'h0b;
        dataWrEn <= 1'b1;
        dataWrData <= v;
        @(posedge mclk);
        dataWrEn <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] exp);
        @(posedge mclk);
        dataAddr <= 8'h0b;
        @(posedge mclk);
        #1 chk({5'h00, dataRdData}, {5'h00, exp});
    endtask : rd
    task ev(input int k);
        @(posedge mclk);
        evt <= 6'h01 << k;
        @(posedge mclk);
        evt <= 6'h00;
    endtask : ev
    // bounded wait: a missing acknowledge shows as a mismatch
    task waitTake(input logic [12:0] vec);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (irqTake !== 1'b1 && n < 20);
        chk({12'h000, irqTake}, 13'h0001);
        chk(irqVector, vec);
    endtask : waitTake
    task noTake;
        logic [12:0] n;
        n = takeCount;
        repeat (12) @(posedge mclk);
        #1 chk(takeCount, n);
    endtask : noTake
    task resetValues;
        rd(8'h00);
        chk({12'h000, wakeRequest}, 13'h0000);
    endtask : resetValues
    task maskedFlags;
        ev(0);
        ev(1);
        ev(2);
        rd(8'h70);
        chk({12'h000, wakeRequest}, 13'h0001);
    endtask : maskedFlags
    task priorityNesting;
        wr(8'h7f);
        waitTake(vic_pkg::VEC_PIN);
        rd(8'h6e);
        wr(8'h6f);
        waitTake(vic_pkg::VEC_TIMER_A);
        rd(8'h4e);
        @(posedge mclk);
        tickEn <= 1'b0;
        ev(5);
        noTake;
        @(posedge mclk);
        tickEn <= 1'b1;
        waitTake(vic_pkg::VEC_TIMER_B);
        rd(8'h0e);
        chk({12'h000, wakeRequest}, 13'h0000);
    endtask : priorityNesting
    // two entries held here; fourteen calls fill sixteen levels
    task stackLimit;
        repeat (13) ev(3);
        #1 chk({12'h000, stackFull}, 13'h0000);
        ev(3);
        repeat (2) @(posedge mclk);
        #1 chk({12'h000, stackFull}, 13'h0001);
        wr(8'h0f);
        ev(2);
        noTake;
        rd(8'h4f);
        ev(4);
        waitTake(vic_pkg::VEC_TIMER_B);
        rd(8'h0e);
    endtask : stackLimit
    task wrapUp;
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrapUp
    // clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // watchdog: whole run needs well under a thousand cycles
    initial begin
        #20000;
        errCount++;
        wrapUp;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        evt = 6'h00;
        dataAddr = 8'h00;
        dataWrEn = 1'b0;
        dataWrData = 8'h00;
        tickEn = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        resetValues;
        maskedFlags;
        priorityNesting;
        stackLimit;
        wrapUp;
    end
endmodule : vectored_interrupt_control_tb
`default_nettype wire

// File: testbench/vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// core side: one phase-two tick per four-clock instruction cycle
module vic_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tickEn,
    output logic secondClockPhase
);
    logic [1:0] phase;
    // tick can be held off so the bench can show requests wait for it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
            secondClockPhase <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            secondClockPhase <= tickEn && phase == 2'h3;
        end
    end
endmodule : vic_core_model
`default_nettype wire
